// [testbench/int_host.sv]
// Purpose: Host side of the interrupt pipe.
// Assumes: One token per request from the bench.
// Notes:   Acknowledges every data packet one edge after it arrives.
`timescale 1ns/100ps
module int_host (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic go_i,
	input  wire logic valid_i,
	output logic      req_o,
	output logic      ack_o
);
	// Token pulse follows the bench request; data is acknowledged promptly.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_o <= 1'h0;
			ack_o <= 1'h0;
		end else begin
			req_o <= go_i;
			ack_o <= valid_i;
		end
	end
endmodule

// [testbench/pin_props.sv]
// Purpose: Port-level assertions for the pin block.
// Assumes: Pin inputs reach the outputs within three edges.
// Notes:   Bound to every instance of the pin block.
`timescale 1ns/100ps
module pin_props
	import pin_ctrl_pkg::*;
(
	input wire logic           SYS_CLK_I,
	input wire logic           RST_N_I,
	input wire logic           S_AXI_AWVALID_I,
	input wire logic           S_AXI_AWREADY_O,
	input wire logic           S_AXI_WVALID_I,
	input wire logic           S_AXI_WREADY_O,
	input wire logic           S_AXI_BVALID_O,
	input wire logic           INT_IN_REQ_I,
	input wire logic           INT_NAK_O,
	input wire logic           INT_DATA_VALID_O,
	input wire logic [15:0]    INT_DATA_O,
	input wire logic           ATA_PORT_ENABLE_I,
	input wire logic           ATA_BUS_OE_O,
	input wire logic           ATA_HALT_O,
	input wire tri_pin_type    PULLUP_RESISTOR_ENABLE_O,
	input wire tri_pin_type    PULLDOWN_RESISTOR_ENABLE_O,
	input wire logic [3:0]     TEST_I,
	input wire gpio_drive_type GPIO_O,
	input wire logic           SCAN_MODE_O,
	input wire logic           FAB_TEST_O
);
	// All checks use the system clock and are off during reset.
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	chk_int_answer: assert property (INT_IN_REQ_I |=> INT_NAK_O != INT_DATA_VALID_O)
		else $error("interrupt token not answered exactly once");
	chk_int_zeros: assert property (INT_DATA_VALID_O |-> INT_DATA_O[15:11] == 5'h0)
		else $error("interrupt report upper bits not zero");
	chk_pu_float: assert property (!ATA_PORT_ENABLE_I [*5] |-> !PULLUP_RESISTOR_ENABLE_O.oe)
		else $error("pull-up enable driven while port disabled");
	chk_pd_float: assert property (!ATA_PORT_ENABLE_I [*5] |-> !PULLDOWN_RESISTOR_ENABLE_O.oe)
		else $error("pull-down enable driven while port disabled");
	chk_ata_float: assert property (!ATA_PORT_ENABLE_I [*5] |-> !ATA_BUS_OE_O && ATA_HALT_O)
		else $error("drive bus not floated and halted");
	chk_quiet_float: assert property ((TEST_I == 4'h2) [*5] |-> GPIO_O.oe == 10'h0)
		else $error("general pins driven in quiet mode");
	chk_scan_code: assert property ((TEST_I == 4'h6) [*5] |-> SCAN_MODE_O && !FAB_TEST_O)
		else $error("scan code not decoded");
	chk_fab_code: assert property ((TEST_I > 4'ha) [*5] |-> FAB_TEST_O)
		else $error("factory code not decoded");
	chk_bresp_time: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
		&& S_AXI_WREADY_O |-> ##3 S_AXI_BVALID_O)
		else $error("write response not three edges after take");
endmodule

bind pin_control_test_modes pin_props i_pin_props (.*);

// [testbench/tb.sv]
// Purpose: Self-checking bench for the pin block.
// Assumes: Bus results are queued by the driver and checked by a monitor.
// Notes:   Pin effects are given six cycles to settle.
`timescale 1ns/100ps
`include "pin_ctrl_defines.svh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb
	import pin_ctrl_pkg::*;
;
	logic SYS_CLK_I = 0, RST_N_I = 0, S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
	logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0, SERVICE_REQUEST_INPUT_I = 0, token = 0;
	logic DRIVE_READY_INPUT_I = 1, IDENT_STRAP_I = 0, FETCH_DONE_I = 0, ATA_PORT_ENABLE_I = 1;
	logic [7:0] S_AXI_AWADDR_I = 0, S_AXI_ARADDR_I = 0, FETCH_CMD_O;
	logic [31:0] S_AXI_WDATA_I = 0, S_AXI_RDATA_O;
	logic [3:0] S_AXI_WSTRB_I = 4'hf, TEST_I = 4'h0, TEST_CODE_O;
	logic [9:0] GPIO_I = 10'h0;
	logic [1:0] LED_I = 2'h0, S_AXI_BRESP_O, S_AXI_RRESP_O;
	logic [47:0] TRANSCEIVER_DEBUG_ROUTE_I = 48'h0;
	logic [11:0] DEDIC_CHAIN_I = 12'hfff;
	logic [16:0] BIDI_CHAIN_I = 17'h1ffff;
	logic [15:0] INT_DATA_O;
	logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
	logic INT_IN_REQ_I, INT_ACK_I, INT_NAK_O, INT_DATA_VALID_O, FETCH_REQ_O, ENUM_PERMIT_O;
	logic ATA_BUS_OE_O, ATA_HALT_O, NAND_RESULT_O, NAND_BIDI_DRIVE_O, NAND_OUT_DRIVE_O;
	logic SHORT_TIMERS_O, SHORT_MEM_O, SKIP_IDENT_O, SCAN_MODE_O, FAB_TEST_O;
	gpio_drive_type GPIO_O;
	tri_pin_type [1:0] INDICATOR_LED_OUT_O;
	tri_pin_type PULLUP_RESISTOR_ENABLE_O, PULLDOWN_RESISTOR_ENABLE_O;
	logic [65:0] aq[$];
	logic [16:0] iq[$];
	int err_total = 0, n_checks = 0;

	pin_control_test_modes i_pin_control_test_modes (.*);
	int_host i_int_host (.clk_i(SYS_CLK_I), .rst_n_i(RST_N_I), .go_i(token),
		.valid_i(INT_DATA_VALID_O), .req_o(INT_IN_REQ_I), .ack_o(INT_ACK_I));

	// Free-running 40 MHz clock.
	always #12.5 SYS_CLK_I = ~SYS_CLK_I;

	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		@(posedge SYS_CLK_I);
		aq.push_back({32'h0, r, 32'h0});
		S_AXI_AWADDR_I <= a;
		S_AXI_WDATA_I <= d;
		S_AXI_WSTRB_I <= s;
		S_AXI_AWVALID_I <= 1'h1;
		S_AXI_WVALID_I <= 1'h1;
		S_AXI_BREADY_I <= 1'h1;
		fork
			begin do @(posedge SYS_CLK_I); while (!S_AXI_AWREADY_O); S_AXI_AWVALID_I <= 1'h0; end
			begin do @(posedge SYS_CLK_I); while (!S_AXI_WREADY_O); S_AXI_WVALID_I <= 1'h0; end
		join
		while (!S_AXI_BVALID_O) @(posedge SYS_CLK_I);
		S_AXI_BREADY_I <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
		@(posedge SYS_CLK_I);
		aq.push_back({m, r, e});
		S_AXI_ARADDR_I <= a;
		S_AXI_ARVALID_I <= 1'h1;
		S_AXI_RREADY_I <= 1'h1;
		do @(posedge SYS_CLK_I); while (!S_AXI_ARREADY_O);
		S_AXI_ARVALID_I <= 1'h0;
		while (!S_AXI_RVALID_O) @(posedge SYS_CLK_I);
		S_AXI_RREADY_I <= 1'h0;
	endtask

	task automatic go;
		@(posedge SYS_CLK_I);
		token <= 1'h1;
		@(posedge SYS_CLK_I);
		token <= 1'h0;
		repeat (6) @(posedge SYS_CLK_I);
	endtask

	// Monitor: every bus answer or interrupt answer takes the oldest note.
	always @(posedge SYS_CLK_I) begin
		logic [65:0] q;
		logic [16:0] p;
		if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
			q = aq.pop_front();
			`CHK("bresp", q[33:32], S_AXI_BRESP_O)
		end
		if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
			q = aq.pop_front();
			`CHK("rdata", q[33:0], {S_AXI_RRESP_O, S_AXI_RDATA_O & q[65:34]})
		end
		if (INT_NAK_O || INT_DATA_VALID_O) begin
			p = iq.pop_front();
			`CHK("intr", p, {INT_NAK_O, INT_DATA_O})
		end
	end

	// Watchdog cuts a hang short.
	initial begin
		#400000;
		err_total++;
		stop_test();
	end

	// Main sequence.
	initial begin
		logic [31:0] d;
		logic [11:0] x, y;
		void'($urandom(62));
		repeat (6) @(posedge SYS_CLK_I);
		RST_N_I <= 1'h1;
		d = $urandom;
		wr(`OFS_GPIO_OUT, d, 4'hf, `RESP_OKAY);
		wr(`OFS_GPIO_OE, ~d, 4'hf, `RESP_OKAY);
		wr(`OFS_GPIO_OUT, ~d, 4'h1, `RESP_OKAY);
		rd(`OFS_GPIO_OUT, {22'h0, d[9:8], ~d[7:0]}, 32'h3ff, `RESP_OKAY);
		rd(`OFS_GPIO_OE, {22'h0, ~d[9:0]}, 32'h3ff, `RESP_OKAY);
		`CHK("gpio", {d[9:8], ~d[7:0], ~d[9:0]}, GPIO_O)
		`CHK("enum", 2'h1, {FETCH_REQ_O, ENUM_PERMIT_O})
		GPIO_I <= d[31:22];
		repeat (4) @(posedge SYS_CLK_I);
		rd(`OFS_GPIO_IN, {22'h0, d[31:22]}, 32'h3ff, `RESP_OKAY);
		rd(8'h10, 32'h0, 32'hffffffff, `RESP_SLVERR);
		wr(8'h10, d, 4'hf, `RESP_SLVERR);
		iq.push_back(17'h10000);
		go();
		SERVICE_REQUEST_INPUT_I <= 1'h1;
		repeat (6) @(posedge SYS_CLK_I);
		iq.push_back({6'h0, 1'h1, d[31:22]});
		go();
		iq.push_back(17'h10000);
		go();
		TRANSCEIVER_DEBUG_ROUTE_I <= {$urandom, d[15:0]};
		for (int c = 0; c < 16; c++) begin
			TEST_I <= c[3:0];
			repeat (6) @(posedge SYS_CLK_I);
			`CHK("code", c[3:0], TEST_CODE_O)
			rd(`OFS_STATUS, {24'h0, c[3:0], 4'h8}, 32'hf8, `RESP_OKAY);
			x = TRANSCEIVER_DEBUG_ROUTE_I[(c[3] ? c - 7 : 0) * 12 +: 12];
			y = {INDICATOR_LED_OUT_O[1].drive, INDICATOR_LED_OUT_O[0].drive, GPIO_O.dout};
			if (c == 1 || c > 7 && c < 11) `CHK("dbg", x, y)
			`CHK("sim", GPIO_I[2:0] & {3{c == 5}}, {SHORT_TIMERS_O, SHORT_MEM_O, SKIP_IDENT_O})
			`CHK("mode", {c == 3, c == 4}, {NAND_BIDI_DRIVE_O, NAND_OUT_DRIVE_O})
		end
		TEST_I <= `TM_NORMAL;
		ATA_PORT_ENABLE_I <= 1'h0;
		repeat (6) @(posedge SYS_CLK_I);
		rd(`OFS_STATUS, 32'h0, 32'h8, `RESP_OKAY);
		ATA_PORT_ENABLE_I <= 1'h1;
		repeat (6) @(posedge SYS_CLK_I);
		y = {ATA_HALT_O, ATA_BUS_OE_O, PULLUP_RESISTOR_ENABLE_O, PULLDOWN_RESISTOR_ENABLE_O};
		`CHK("halt", 12'h01d, y)
		TEST_I <= `TM_NAND_IN;
		for (int i = 0; i < 3; i++) begin
			DEDIC_CHAIN_I[0] <= i[0] ? 1'h0 : 1'h1;
			repeat (6) @(posedge SYS_CLK_I);
			`CHK("nand", ~i[0], NAND_RESULT_O)
		end
		// Second reset with the strap high: fetch first, enumeration after it.
		IDENT_STRAP_I <= 1'h1;
		RST_N_I <= 1'h0;
		repeat (6) @(posedge SYS_CLK_I);
		RST_N_I <= 1'h1;
		repeat (6) @(posedge SYS_CLK_I);
		`CHK("ident", 2'h2, {FETCH_REQ_O, ENUM_PERMIT_O})
		FETCH_DONE_I <= 1'h1;
		repeat (6) @(posedge SYS_CLK_I);
		`CHK("fetched", 2'h1, {FETCH_REQ_O, ENUM_PERMIT_O})
		stop_test();
	end
endmodule

// [verilog/pin_control_test_modes.sv]
// Purpose: GPIO, interrupt-pipe report, identify strap, ATA enable and test modes.
// Assumes: One 40 MHz clock; GPIO, chain, ready, service-request, ATA enable, test and strap pins are synchronised here.
// Notes on behaviour
// - Each GPIO pin has its own output enable.
// - GPIO in, out, enable mapped to registers.
// - Upper two pins sampled one clock earlier.
// - Upper two pins latched one clock earlier.
// - Strap high: configuration fetched by drive command.
// - Strap mode: fetch done before enumeration allowed.
// - Interrupt IN with nothing pending gets NAK.
// - Report: pins, pins 9..8, ready, zeros.
// - Enable low floats ATA, halts ATA engines.
// - Enable high resumes ATA operation.
// - Pull-up enable output floats when disabled.
// - Pull-down enable output floats when disabled.
// - Code 0000 normal mode, pull-up on, pull-down off.
// - Four debug codes route transceiver signals out.
// - Quiet code floats every output except oscillator.
// - Input chain result drives bidirectional pins.
// - Bidirectional pins chain; result on outputs.
// - Simulation code: GPIO 2,1,0 select shortcuts.
// - Scan, reserved and factory test-bus codes.
// - All ones gives one; each step toggles.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "pin_ctrl_defines.svh"
module pin_control_test_modes
	import pin_ctrl_pkg::*;
#(
	parameter int DEDIC_W = 12,
	parameter int BIDI_W  = 17
) (
	input  wire logic                  SYS_CLK_I,
	input  wire logic                  RST_N_I,
	input  wire logic                  S_AXI_AWVALID_I,
	output logic                       S_AXI_AWREADY_O,
	input  wire logic [7:0]            S_AXI_AWADDR_I,
	input  wire logic                  S_AXI_WVALID_I,
	output logic                       S_AXI_WREADY_O,
	input  wire logic [31:0]           S_AXI_WDATA_I,
	input  wire logic [3:0]            S_AXI_WSTRB_I,
	output logic                       S_AXI_BVALID_O,
	input  wire logic                  S_AXI_BREADY_I,
	output logic [1:0]                 S_AXI_BRESP_O,
	input  wire logic                  S_AXI_ARVALID_I,
	output logic                       S_AXI_ARREADY_O,
	input  wire logic [7:0]            S_AXI_ARADDR_I,
	output logic                       S_AXI_RVALID_O,
	input  wire logic                  S_AXI_RREADY_I,
	output logic [31:0]                S_AXI_RDATA_O,
	output logic [1:0]                 S_AXI_RRESP_O,
	input  wire logic [`GPIO_W-1:0]    GPIO_I,
	output gpio_drive_type             GPIO_O,
	input  wire logic [1:0]            LED_I,
	output tri_pin_type [1:0]          INDICATOR_LED_OUT_O,
	input  wire logic [4*`DBG_W-1:0]   TRANSCEIVER_DEBUG_ROUTE_I,
	input  wire logic                  SERVICE_REQUEST_INPUT_I,
	input  wire logic                  DRIVE_READY_INPUT_I,
	input  wire logic                  INT_IN_REQ_I,
	input  wire logic                  INT_ACK_I,
	output logic                       INT_NAK_O,
	output logic                       INT_DATA_VALID_O,
	output logic [15:0]                INT_DATA_O,
	input  wire logic                  IDENT_STRAP_I,
	input  wire logic                  FETCH_DONE_I,
	output logic                       FETCH_REQ_O,
	output logic [7:0]                 FETCH_CMD_O,
	output logic                       ENUM_PERMIT_O,
	input  wire logic                  ATA_PORT_ENABLE_I,
	output logic                       ATA_BUS_OE_O,
	output logic                       ATA_HALT_O,
	output tri_pin_type                PULLUP_RESISTOR_ENABLE_O,
	output tri_pin_type                PULLDOWN_RESISTOR_ENABLE_O,
	input  wire logic [3:0]            TEST_I,
	input  wire logic [DEDIC_W-1:0]    DEDIC_CHAIN_I,
	input  wire logic [BIDI_W-1:0]     BIDI_CHAIN_I,
	output logic                       NAND_RESULT_O,
	output logic                       NAND_BIDI_DRIVE_O,
	output logic                       NAND_OUT_DRIVE_O,
	output logic                       SHORT_TIMERS_O,
	output logic                       SHORT_MEM_O,
	output logic                       SKIP_IDENT_O,
	output logic                       SCAN_MODE_O,
	output logic                       FAB_TEST_O,
	output logic [3:0]                 TEST_CODE_O
);
	localparam int GW  = `GPIO_W;
	localparam int HL  = `GPIO_HI_LSB;
	localparam int NSY = GW + DEDIC_W + BIDI_W + 2 + 1 + 4 + 1;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [NSY-1:0]     sync_q;
	logic [GW-1:0]      gpio_s;
	logic [DEDIC_W-1:0] dedic_s;
	logic [BIDI_W-1:0]  bidi_s;
	logic               rdy_s;
	logic               srq_s;
	logic               ata_port_enable_s;
	logic [3:0]         test_s;
	logic               strap_s;

	sync_bank #(
		.W (NSY)
	) u_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     ({GPIO_I, DEDIC_CHAIN_I, BIDI_CHAIN_I, DRIVE_READY_INPUT_I,
			SERVICE_REQUEST_INPUT_I, ATA_PORT_ENABLE_I, TEST_I, IDENT_STRAP_I}),
		.q_o     (sync_q)
	);

	// Split the synchronised bank into named fields.
	assign {gpio_s, dedic_s, bidi_s, rdy_s, srq_s, ata_port_enable_s, test_s, strap_s} = sync_q;

	// ****************************************************************
	// Test-mode decode
	// ****************************************************************
	wire mode_quiet    = (test_s == `TM_QUIET);
	wire mode_nand_in  = (test_s == `TM_NAND_IN);
	wire mode_nand_bi  = (test_s == `TM_NAND_BIDI);
	wire mode_sim      = (test_s == `TM_SIM);
	wire mode_scan     = (test_s == `TM_SCAN);
	wire mode_fab      = test_s[3] & (test_s[2] | (test_s[1] & test_s[0]));
	wire mode_dbg1     = (test_s == `TM_DEBUG1);
	wire mode_dbg2     = (test_s == `TM_DEBUG2);
	wire mode_dbg3     = (test_s == `TM_DEBUG3);
	wire mode_dbg4     = (test_s == `TM_DEBUG4);
	wire mode_dbg      = mode_dbg1 | mode_dbg2 | mode_dbg3 | mode_dbg4;
	wire mode_nand     = mode_nand_in | mode_nand_bi;
	wire [1:0] dbg_sel = mode_dbg4 ? 2'h3 : mode_dbg3 ? 2'h2 : mode_dbg2 ? 2'h1 : 2'h0;
	wire [`DBG_W-1:0] dbg_bus = TRANSCEIVER_DEBUG_ROUTE_I[dbg_sel*`DBG_W +: `DBG_W];

	// ****************************************************************
	// NAND chains
	// ****************************************************************
	localparam int BCH = GW + BIDI_W;
	logic [DEDIC_W-1:0] chain_in;
	logic [BCH-1:0]     chain_bi;
	logic [BCH-1:0]     bi_src;

	// GPIO 0 first, then the other bidirectional pins.
	assign bi_src = {bidi_s, gpio_s};

	// Each link is a NAND of the previous link and the next input.
	assign chain_in[0] = dedic_s[0];
	assign chain_bi[0] = bi_src[0];
	for (genvar k = 1; k < DEDIC_W; k++) begin : g_in
		assign chain_in[k] = ~(chain_in[k-1] & dedic_s[k]);
	end
	for (genvar k = 1; k < BCH; k++) begin : g_bi
		assign chain_bi[k] = ~(chain_bi[k-1] & bi_src[k]);
	end

	// An even-length chain yields zero with all ones, so it is inverted.
	wire fix_in = ((DEDIC_W % 2) == 0);
	wire fix_bi = ((BCH % 2) == 0);
	wire nand_res = mode_nand_in ? (chain_in[DEDIC_W-1] ^ fix_in)
		: (chain_bi[BCH-1] ^ fix_bi);

	// ****************************************************************
	// Identify strap and configuration fetch
	// ****************************************************************
	logic       strap_taken_q;
	logic       ident_q;
	logic       fetch_done_q;
	logic [1:0] strap_wait_q;

	// The strap is caught once the synchroniser holds its true level, then held.
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			strap_wait_q  <= 2'd0;
			strap_taken_q <= 1'b0;
			ident_q       <= 1'b0;
		end else if (!strap_taken_q) begin
			if (strap_wait_q == `STRAP_SETTLE) begin
				strap_taken_q <= 1'b1;
				ident_q       <= strap_s;
			end else begin
				strap_wait_q <= strap_wait_q + 2'd1;
			end
		end
	end

	// Completion of the drive fetch is sticky.
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			fetch_done_q <= 1'b0;
		end else if (FETCH_DONE_I && ident_q) begin
			fetch_done_q <= 1'b1;
		end
	end

	wire fetch_req_d = strap_taken_q & ident_q & ~fetch_done_q & ata_port_enable_s;
	wire enum_ok_d   = strap_taken_q & (~ident_q | fetch_done_q);

	// ****************************************************************
	// Interrupt pipe
	// ****************************************************************
	logic        srq_prev_q;
	logic        pend_q;
	logic [15:0] snap_q;

	wire srq_rise = srq_s & ~srq_prev_q;
	wire int_send = INT_IN_REQ_I & pend_q;
	wire [15:0] snap_d = {5'h00, rdy_s, gpio_s[9:8], gpio_s[7:0]};

	// A new request wins over a simultaneous acknowledge.
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			srq_prev_q <= 1'b0;
			pend_q     <= 1'b0;
			snap_q     <= 16'h0000;
		end else begin
			srq_prev_q <= srq_s;
			if (srq_rise) begin
				pend_q <= 1'b1;
				snap_q <= snap_d;
			end else if (INT_ACK_I) begin
				pend_q <= 1'b0;
			end
		end
	end

	// One-cycle answer to each interrupt IN request.
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			INT_NAK_O        <= 1'b0;
			INT_DATA_VALID_O <= 1'b0;
			INT_DATA_O       <= 16'h0000;
		end else begin
			INT_NAK_O        <= INT_IN_REQ_I & ~pend_q;
			INT_DATA_VALID_O <= int_send;
			INT_DATA_O       <= int_send ? snap_q : 16'h0000;
		end
	end

	// ****************************************************************
	// Register bus
	// ****************************************************************
	logic [GW-1:0] out_q;
	logic [GW-1:0] oe_q;
	logic [GW-1:0] in_q;
	logic          aw_held_q;
	logic          w_held_q;
	logic [7:0]    awaddr_q;
	logic [31:0]   wdata_q;
	logic [3:0]    wstrb_q;
	logic          wr_busy_q;
	wr_step_type   wr_step_q;
	logic [1:0]    rd_step_q;
	logic [7:0]    araddr_q;

	wire aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
	wire w_take  = S_AXI_WVALID_I & S_AXI_WREADY_O;
	wire ar_take = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
	wire b_done  = S_AXI_BVALID_O & S_AXI_BREADY_I;
	wire r_done  = S_AXI_RVALID_O & S_AXI_RREADY_I;
	wire wr_go   = aw_held_q & w_held_q & ~wr_busy_q & ~S_AXI_BVALID_O;
	wire wr_out  = (awaddr_q == `OFS_GPIO_OUT);
	wire wr_oe   = (awaddr_q == `OFS_GPIO_OE);
	wire wr_hit  = wr_out | wr_oe;
	wire rd_hit  = (araddr_q == `OFS_GPIO_OUT) | (araddr_q == `OFS_GPIO_OE)
		| (araddr_q == `OFS_GPIO_IN) | (araddr_q == `OFS_STATUS);

	// Address and data may arrive in either order.
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= {S_AXI_AWADDR_I[7:2], 2'b00};
			end else if (b_done) begin
				aw_held_q <= 1'b0;
			end
			if (w_take) begin
				w_held_q <= 1'b1;
				wdata_q  <= S_AXI_WDATA_I;
				wstrb_q  <= S_AXI_WSTRB_I;
			end else if (b_done) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Ready flops drop on a take and rise once the response is consumed.
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			S_AXI_ARREADY_O <= 1'b0;
		end else begin
			S_AXI_AWREADY_O <= ~aw_held_q & ~aw_take | b_done;
			S_AXI_WREADY_O  <= ~w_held_q & ~w_take | b_done;
			S_AXI_ARREADY_O <= (rd_step_q == 2'd0) & ~S_AXI_RVALID_O & ~ar_take
				| r_done;
		end
	end

	// Pins 9..8 are written in the first step, 7..0 in the next.
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_busy_q      <= 1'b0;
			wr_step_q      <= WR_STEP_HI;
			out_q          <= `RST_GPIO_OUT;
			oe_q           <= `RST_GPIO_OE;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O  <= `RESP_OKAY;
		end else begin
			unique case (wr_step_q)
				WR_STEP_HI: begin
					if (wr_go) begin
						wr_busy_q <= 1'b1;
						wr_step_q <= WR_STEP_LO;
						if (wr_out && wstrb_q[1]) begin
							out_q[GW-1:HL] <= wdata_q[GW-1:HL];
						end
						if (wr_oe && wstrb_q[1]) begin
							oe_q[GW-1:HL] <= wdata_q[GW-1:HL];
						end
					end
				end
				WR_STEP_LO: begin
					wr_step_q      <= WR_STEP_HI;
					S_AXI_BVALID_O <= 1'b1;
					S_AXI_BRESP_O  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
					if (wr_out && wstrb_q[0]) begin
						out_q[HL-1:0] <= wdata_q[HL-1:0];
					end
					if (wr_oe && wstrb_q[0]) begin
						oe_q[HL-1:0] <= wdata_q[HL-1:0];
					end
				end
			endcase
			if (b_done) begin
				S_AXI_BVALID_O <= 1'b0;
				wr_busy_q      <= 1'b0;
			end
		end
	end

	// Read: sample pins 9..8, then 7..0, then answer.
	wire [31:0] status_w = {24'h00_0000, test_s, ata_port_enable_s, enum_ok_d, ident_q, pend_q};
	wire [31:0] rd_word  = (araddr_q == `OFS_GPIO_OUT) ? {22'h0, out_q}
		: (araddr_q == `OFS_GPIO_OE) ? {22'h0, oe_q}
		: (araddr_q == `OFS_GPIO_IN) ? {22'h0, in_q}
		: (araddr_q == `OFS_STATUS) ? status_w : 32'h0000_0000;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rd_step_q      <= 2'd0;
			araddr_q       <= 8'h00;
			in_q           <= '0;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O  <= 32'h0000_0000;
			S_AXI_RRESP_O  <= `RESP_OKAY;
		end else begin
			if (ar_take) begin
				araddr_q  <= {S_AXI_ARADDR_I[7:2], 2'b00};
				in_q[GW-1:HL] <= gpio_s[GW-1:HL];
				rd_step_q <= 2'd1;
			end else if (rd_step_q == 2'd1) begin
				in_q[HL-1:0] <= gpio_s[HL-1:0];
				rd_step_q    <= 2'd2;
			end else if (rd_step_q == 2'd2) begin
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RDATA_O  <= rd_word;
				S_AXI_RRESP_O  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
				rd_step_q      <= 2'd0;
			end
			if (r_done) begin
				S_AXI_RVALID_O <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Pin drive selection
	// ****************************************************************
	wire [GW-1:0] gpio_dout_d = mode_nand_in ? {GW{nand_res}}
		: mode_dbg ? dbg_bus[GW-1:0] : out_q;
	wire [GW-1:0] gpio_oe_d = (mode_quiet | mode_nand_bi | mode_sim) ? '0
		: (mode_nand_in | mode_dbg) ? {GW{1'b1}} : oe_q;
	wire [1:0] led_d  = mode_nand_bi ? {2{nand_res}}
		: mode_dbg ? dbg_bus[GW+1:GW] : LED_I;
	wire       led_oe = ~(mode_quiet | mode_nand_in);
	wire       ata_on = ata_port_enable_s & ~mode_quiet & ~mode_nand;
	// Pull-up on and pull-down off while operating; floated when disabled.
	wire       pu_oe  = (ata_on | mode_nand_bi) & ata_port_enable_s;
	wire       pd_oe  = (ata_on | mode_nand_bi) & ata_port_enable_s;
	wire       pu_d   = mode_nand_bi ? nand_res : 1'b1;
	wire       pd_d   = mode_nand_bi ? nand_res : 1'b0;

	// All top outputs leave from flops.
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			GPIO_O                     <= '0;
			INDICATOR_LED_OUT_O        <= '0;
			PULLUP_RESISTOR_ENABLE_O   <= '0;
			PULLDOWN_RESISTOR_ENABLE_O <= '0;
			ATA_BUS_OE_O               <= 1'b0;
			ATA_HALT_O                 <= 1'b1;
			FETCH_REQ_O                <= 1'b0;
			FETCH_CMD_O                <= `IDENT_CMD;
			ENUM_PERMIT_O              <= 1'b0;
		end else begin
			GPIO_O.dout <= gpio_dout_d;
			GPIO_O.oe   <= gpio_oe_d;
			for (int i = 0; i < 2; i++) begin
				INDICATOR_LED_OUT_O[i].drive <= led_d[i];
				INDICATOR_LED_OUT_O[i].oe    <= led_oe;
			end
			PULLUP_RESISTOR_ENABLE_O.drive   <= pu_d;
			PULLUP_RESISTOR_ENABLE_O.oe      <= pu_oe;
			PULLDOWN_RESISTOR_ENABLE_O.drive <= pd_d;
			PULLDOWN_RESISTOR_ENABLE_O.oe    <= pd_oe;
			ATA_BUS_OE_O  <= ata_on;
			ATA_HALT_O    <= ~ata_port_enable_s;
			FETCH_REQ_O   <= fetch_req_d;
			FETCH_CMD_O   <= `IDENT_CMD;
			ENUM_PERMIT_O <= enum_ok_d;
		end
	end

	// Test-mode side outputs.
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			NAND_RESULT_O     <= 1'b0;
			NAND_BIDI_DRIVE_O <= 1'b0;
			NAND_OUT_DRIVE_O  <= 1'b0;
			SHORT_TIMERS_O    <= 1'b0;
			SHORT_MEM_O       <= 1'b0;
			SKIP_IDENT_O      <= 1'b0;
			SCAN_MODE_O       <= 1'b0;
			FAB_TEST_O        <= 1'b0;
			TEST_CODE_O       <= `TM_NORMAL;
		end else begin
			NAND_RESULT_O     <= mode_nand & nand_res;
			NAND_BIDI_DRIVE_O <= mode_nand_in;
			NAND_OUT_DRIVE_O  <= mode_nand_bi;
			SHORT_TIMERS_O    <= mode_sim & gpio_s[2];
			SHORT_MEM_O       <= mode_sim & gpio_s[1];
			SKIP_IDENT_O      <= mode_sim & gpio_s[0];
			SCAN_MODE_O       <= mode_scan;
			FAB_TEST_O        <= mode_fab;
			TEST_CODE_O       <= test_s;
		end
	end
endmodule

// [verilog/pin_ctrl_defines.svh]
// Purpose: Offsets, field positions, reset values and codes of the pin block.
// Assumes: Word-aligned AXI4-Lite register map, 32-bit data.
// Notes:   Definitions only.
`ifndef PIN_CTRL_DEFINES_SVH
`define PIN_CTRL_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define OFS_GPIO_OUT     8'h00
`define OFS_GPIO_OE      8'h04
`define OFS_GPIO_IN      8'h08
`define OFS_STATUS       8'h0c
`define RST_GPIO_OUT     10'h000
`define RST_GPIO_OE      10'h000

// ****************************************************************
// Fields
// ****************************************************************
`define GPIO_W           10
`define GPIO_HI_LSB      8
`define INT_RDY_BIT      2
`define ST_PEND_BIT      0
`define ST_IDENT_BIT     1
`define ST_ENUM_BIT      2
`define ST_ATA_PORT_ENABLE_BIT    3
`define ST_MODE_LSB      4

// ****************************************************************
// Codes
// ****************************************************************
`define IDENT_CMD        8'hfb
`define STRAP_SETTLE     2'd2
`define TM_NORMAL        4'h0
`define TM_DEBUG1        4'h1
`define TM_QUIET         4'h2
`define TM_NAND_IN       4'h3
`define TM_NAND_BIDI     4'h4
`define TM_SIM           4'h5
`define TM_SCAN          4'h6
`define TM_RSVD          4'h7
`define TM_DEBUG2        4'h8
`define TM_DEBUG3        4'h9
`define TM_DEBUG4        4'ha
`define DBG_W            12
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// [verilog/pin_ctrl_pkg.sv]
// Purpose: Types shared by the pin block files.
// Assumes: Ten general-purpose pins.
// Notes:   Constants live in pin_ctrl_defines.svh.
package pin_ctrl_pkg;
	typedef enum logic [1:0] {
		WR_STEP_HI,
		WR_STEP_LO
	} wr_step_type;

	typedef struct packed {
		logic [9:0] dout;
		logic [9:0] oe;
	} gpio_drive_type;

	typedef struct packed {
		logic       drive;
		logic       oe;
	} tri_pin_type;
endpackage

// [verilog/sync_bank.sv]
// Purpose: Two-flop synchroniser for a bank of asynchronous pins.
// Assumes: Each bit is an independent level.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module sync_bank #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	// Two stages, cleared to zero under reset.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule
